// *** include/pss_pkg.sv ***
package pss_pkg;
  typedef enum logic [2:0] {
    PSS_K_NONE,
    PSS_K_RESET,
    PSS_K_CAL_READ,
    PSS_K_CONVERT,
    PSS_K_RESULT_READ
  } pss_kind_t;

  typedef struct packed {
    pss_kind_t  kind;
    logic       temp_sel;
    logic [2:0] field;
  } pss_cmd_t;

  typedef struct packed {
    logic sclk;
    logic data;
    logic cs_n;
    logic ps;
  } pss_pins_t;

  typedef enum logic [2:0] {
    PSS_I_IDLE,
    PSS_I_ADDR,
    PSS_I_AACK,
    PSS_I_CMD,
    PSS_I_CACK,
    PSS_I_TX,
    PSS_I_MACK
  } pss_i2c_t;
endpackage : pss_pkg

// *** include/pss_regs.svh ***
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH
// ----------------------------------------------------------------
// calibration memory word offsets
// ----------------------------------------------------------------
`define PSS_CAL_FACTORY_SETUP_WORD   3'h0
`define PSS_CAL_COEFFICIENT_WORDS    3'h1
`define PSS_CAL_SERIAL_CHECK_WORD    3'h7
`define PSS_CAL_WORDS                8
`define PSS_CAL_WORD_BITS            16
// ----------------------------------------------------------------
// command codes and fields
// ----------------------------------------------------------------
`define PSS_CMD_RESET                8'h1E
`define PSS_CMD_RESULT_READ          8'h00
`define PSS_CMD_CAL_READ_HI          4'hA
`define PSS_CMD_CONV_HI              3'h2
`define PSS_RATIO_MAX                3'h4
`define PSS_I2C_ADDR_PREFIX          6'h3B
// ----------------------------------------------------------------
// response sizes in bytes
// ----------------------------------------------------------------
`define PSS_RESP_RESULT_BYTES        2'h3
`define PSS_RESP_CAL_BYTES           2'h2
`define PSS_BITS_PER_BYTE            4'h8
// ----------------------------------------------------------------
// timing: clock period and conversion times in ns
// ----------------------------------------------------------------
`define PSS_CLK_NS                   10
`define PSS_TC_256_NS                540000
`define PSS_TC_512_NS                1060000
`define PSS_TC_1024_NS               2080000
`define PSS_TC_2048_NS               4130000
`define PSS_TC_4096_NS               8220000
`endif

// *** logic/pss_port.sv ***
`timescale 1ns/1ns
`include "pss_regs.svh"

// ----------------------------------------------------------------
// response byte fifo
// ----------------------------------------------------------------
module pss_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_r];
  assign push      = in_valid & in_ready & ~flush;
  assign pop       = out_valid & out_ready & ~flush;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn || flush) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wr_r <= (wr_r == AW'(D-1)) ? '0 : wr_r + 1'b1;
      if (pop)  rd_r <= (rd_r == AW'(D-1)) ? '0 : rd_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : pss_fifo

// Contract
// - protocol pin low selects SPI on data, output, select; high selects I2C.
// - SPI accepts clock modes 0 and 3: sample rising, shift falling.
// - active-low select enables SPI; may rise between commands or mid-conversion.
// - I2C address low bit equals inverse of the select line level.
// - I2C answers on the same two-way data line, no chip select.
// - every command is one byte; four command kinds are recognised.
// - reset 0x1E reloads calibration memory and clears unknown state.
// - 0x40-0x48 convert pressure, 0x50-0x58 temperature, ratio 256 to 4096.
// - result read 0x00 after conversion returns 24 bits, msb first.
// - 0xA0-0xAE read calibration word at bits 3..1, 16 bits msb first.
// - calibration memory holds eight 16-bit words, 128 bits.
// - read without completed conversion, or repeated read, returns zeros.
// - read during conversion returns zero, conversion runs on, result corrupt.
// - I2C address is 111011 followed by inverted select bit.
// - device stays busy until conversion ends; only then result valid.
// - I2C result read is 24 bits with host acknowledge after each byte.
module pss_port #(
  parameter int CONV_CYC_256  = `PSS_TC_256_NS / `PSS_CLK_NS,
  parameter int CONV_CYC_512  = `PSS_TC_512_NS / `PSS_CLK_NS,
  parameter int CONV_CYC_1024 = `PSS_TC_1024_NS / `PSS_CLK_NS,
  parameter int CONV_CYC_2048 = `PSS_TC_2048_NS / `PSS_CLK_NS,
  parameter int CONV_CYC_4096 = `PSS_TC_4096_NS / `PSS_CLK_NS,
  parameter int FIFO_DEPTH    = 8
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic         sclk,
  input  wire logic         sdi_sda_in,
  output logic              sda_o,
  output logic              sda_oe_n,
  output logic              sdo,
  input  wire logic         select_line_low_active_n,
  input  wire logic         protocol_select_pin,
  input  wire logic [127:0] calibration_memory,
  input  wire logic [23:0]  raw_pressure_value,
  input  wire logic [23:0]  raw_temperature_value,
  output logic              conversion_busy
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  pss_pkg::pss_pins_t s1_r, s2_r, s3_r, flt_r, prev_r, raw;
  assign raw = '{sclk: sclk, data: sdi_sda_in, cs_n: select_line_low_active_n,
                 ps: protocol_select_pin};

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      s1_r   <= '1;
      s2_r   <= '1;
      s3_r   <= '1;
      flt_r  <= '1;
      prev_r <= '1;
    end else begin
      s1_r   <= raw;
      s2_r   <= s1_r;
      s3_r   <= s2_r;
      // a level counts only once two stages agree; glitches are held off
      flt_r  <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & flt_r);
      prev_r <= flt_r;
    end
  end

  logic spi_mode, sclk_rise, sclk_fall, i2c_start, i2c_stop;
  assign spi_mode  = ~flt_r.ps;
  assign sclk_rise = flt_r.sclk & ~prev_r.sclk;
  assign sclk_fall = ~flt_r.sclk & prev_r.sclk;
  assign i2c_start = ~spi_mode & flt_r.sclk & prev_r.sclk & prev_r.data & ~flt_r.data;
  assign i2c_stop  = ~spi_mode & flt_r.sclk & prev_r.sclk & ~prev_r.data & flt_r.data;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  function automatic pss_pkg::pss_cmd_t decode(input logic [7:0] c);
    pss_pkg::pss_cmd_t d;
    d = '{kind: pss_pkg::PSS_K_NONE, temp_sel: c[4], field: c[3:1]};
    if (c == `PSS_CMD_RESET) d.kind = pss_pkg::PSS_K_RESET;
    else if (c == `PSS_CMD_RESULT_READ) d.kind = pss_pkg::PSS_K_RESULT_READ;
    else if (c[7:4] == `PSS_CMD_CAL_READ_HI && !c[0])
      d.kind = pss_pkg::PSS_K_CAL_READ;
    else if (c[7:5] == `PSS_CMD_CONV_HI && !c[0] && c[3:1] <= `PSS_RATIO_MAX)
      d.kind = pss_pkg::PSS_K_CONVERT;
    return d;
  endfunction : decode

  function automatic logic [19:0] conv_len(input logic [2:0] r);
    unique case (r)
      3'h0:    return 20'(CONV_CYC_256);
      3'h1:    return 20'(CONV_CYC_512);
      3'h2:    return 20'(CONV_CYC_1024);
      3'h3:    return 20'(CONV_CYC_2048);
      default: return 20'(CONV_CYC_4096);
    endcase
  endfunction : conv_len

  // ----------------------------------------------------------------
  // serial link: spi and i2c share shift registers
  // ----------------------------------------------------------------
  pss_pkg::pss_i2c_t i2c_r;
  logic [7:0] rx_r, tx_r, cmd_byte_r, fifo_data;
  logic [3:0] bit_r;
  logic       cmd_stb_r, resp_on_r, drive_low_r, mack_ok_r, rw_r;
  logic       fifo_valid, fifo_ready, load_byte;
  logic [6:0] my_addr;
  pss_pkg::pss_cmd_t rx_dec;

  assign my_addr = {`PSS_I2C_ADDR_PREFIX, ~flt_r.cs_n};
  assign rx_dec  = decode({rx_r[6:0], flt_r.data});
  assign load_byte = spi_mode ? (~flt_r.cs_n & resp_on_r & sclk_fall & bit_r == '0)
                              : (sclk_fall & ((i2c_r == pss_pkg::PSS_I_AACK & rw_r) |
                                 (i2c_r == pss_pkg::PSS_I_MACK & mack_ok_r)));

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      i2c_r       <= pss_pkg::PSS_I_IDLE;
      rx_r        <= '0;
      tx_r        <= '0;
      bit_r       <= '0;
      cmd_stb_r   <= 1'b0;
      cmd_byte_r  <= '0;
      resp_on_r   <= 1'b0;
      drive_low_r <= 1'b0;
      mack_ok_r   <= 1'b0;
      rw_r        <= 1'b0;
    end else begin
      cmd_stb_r <= 1'b0;
      if (load_byte) tx_r <= fifo_valid ? fifo_data : '0;
      if (spi_mode) begin
        drive_low_r <= 1'b0;
        i2c_r       <= pss_pkg::PSS_I_IDLE;
        if (flt_r.cs_n) begin
          bit_r     <= '0;
          resp_on_r <= 1'b0;
          tx_r      <= '0;
        end else if (!resp_on_r && sclk_rise) begin
          rx_r  <= {rx_r[6:0], flt_r.data};
          bit_r <= bit_r + 1'b1;
          if (bit_r == `PSS_BITS_PER_BYTE - 1'b1) begin
            cmd_stb_r  <= 1'b1;
            cmd_byte_r <= {rx_r[6:0], flt_r.data};
            bit_r      <= '0;
            resp_on_r  <= rx_dec.kind inside {pss_pkg::PSS_K_CAL_READ,
                                              pss_pkg::PSS_K_RESULT_READ};
          end
        end else if (resp_on_r && sclk_fall) begin
          if (bit_r != '0) tx_r <= {tx_r[6:0], 1'b0};
          bit_r <= {1'b0, bit_r[2:0] + 3'h1};
        end
      end else if (i2c_start) begin
        i2c_r       <= pss_pkg::PSS_I_ADDR;
        bit_r       <= '0;
        drive_low_r <= 1'b0;
      end else if (i2c_stop) begin
        i2c_r       <= pss_pkg::PSS_I_IDLE;
        drive_low_r <= 1'b0;
      end else if (sclk_rise) begin
        unique case (i2c_r)
          pss_pkg::PSS_I_ADDR, pss_pkg::PSS_I_CMD: begin
            rx_r  <= {rx_r[6:0], flt_r.data};
            bit_r <= bit_r + 1'b1;
          end
          pss_pkg::PSS_I_TX:   bit_r <= bit_r + 1'b1;
          pss_pkg::PSS_I_MACK: mack_ok_r <= ~flt_r.data;
          default: ;
        endcase
      end else if (sclk_fall) begin
        unique case (i2c_r)
          pss_pkg::PSS_I_ADDR: if (bit_r == `PSS_BITS_PER_BYTE) begin
            if (rx_r[7:1] == my_addr) begin
              i2c_r       <= pss_pkg::PSS_I_AACK;
              rw_r        <= rx_r[0];
              drive_low_r <= 1'b1;
            end else begin
              i2c_r <= pss_pkg::PSS_I_IDLE;
            end
          end
          pss_pkg::PSS_I_CMD: if (bit_r == `PSS_BITS_PER_BYTE) begin
            i2c_r       <= pss_pkg::PSS_I_CACK;
            drive_low_r <= 1'b1;
            cmd_stb_r   <= 1'b1;
            cmd_byte_r  <= rx_r;
          end
          pss_pkg::PSS_I_AACK, pss_pkg::PSS_I_CACK, pss_pkg::PSS_I_MACK: begin
            bit_r <= '0;
            if (load_byte) begin
              i2c_r       <= pss_pkg::PSS_I_TX;
              drive_low_r <= fifo_valid ? ~fifo_data[7] : 1'b1;
            end else if (i2c_r == pss_pkg::PSS_I_MACK) begin
              i2c_r       <= pss_pkg::PSS_I_IDLE;
              drive_low_r <= 1'b0;
            end else begin
              i2c_r       <= pss_pkg::PSS_I_CMD;
              drive_low_r <= 1'b0;
            end
          end
          pss_pkg::PSS_I_TX: begin
            if (bit_r == `PSS_BITS_PER_BYTE) begin
              i2c_r       <= pss_pkg::PSS_I_MACK;
              drive_low_r <= 1'b0;
              mack_ok_r   <= 1'b0;
            end else begin
              tx_r        <= {tx_r[6:0], 1'b0};
              drive_low_r <= ~tx_r[6];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // open-drain data line: only ever pulls low
  assign sda_o    = 1'b0;
  assign sda_oe_n = ~(drive_low_r & ~spi_mode);
  assign sdo      = tx_r[7];

  // ----------------------------------------------------------------
  // conversion engine and calibration memory
  // ----------------------------------------------------------------
  logic [7:0][15:0] cal_r;
  logic [19:0]      conv_cnt_r;
  logic [23:0]      result_r, resp_r;
  logic [1:0]       resp_n_r;
  logic             busy_r, valid_r, corrupt_r, temp_r, conv_done;
  pss_pkg::pss_cmd_t cmd;

  assign cmd       = decode(cmd_byte_r);
  assign conv_done = busy_r & (conv_cnt_r == 20'h00001);
  assign conversion_busy = busy_r;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cal_r <= '0;
    end else if (cmd_stb_r && cmd.kind == pss_pkg::PSS_K_RESET) begin
      cal_r <= calibration_memory;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      busy_r     <= 1'b0;
      valid_r    <= 1'b0;
      corrupt_r  <= 1'b0;
      temp_r     <= 1'b0;
      conv_cnt_r <= '0;
      result_r   <= '0;
    end else begin
      if (busy_r) conv_cnt_r <= conv_cnt_r - 1'b1;
      if (cmd_stb_r) begin
        unique case (cmd.kind)
          pss_pkg::PSS_K_RESET: begin
            busy_r    <= 1'b0;
            valid_r   <= 1'b0;
            corrupt_r <= 1'b0;
          end
          pss_pkg::PSS_K_CONVERT: begin
            // a second start mid-conversion is not restarted, just poisons it
            if (busy_r) corrupt_r <= 1'b1;
            else begin
              busy_r     <= 1'b1;
              valid_r    <= 1'b0;
              temp_r     <= cmd.temp_sel;
              conv_cnt_r <= conv_len(cmd.field);
            end
          end
          pss_pkg::PSS_K_RESULT_READ: begin
            valid_r <= 1'b0;
            if (busy_r) corrupt_r <= 1'b1;
          end
          default: ;
        endcase
      end
      // completion is applied last so a same-cycle clear loses
      if (conv_done) begin
        busy_r    <= 1'b0;
        valid_r   <= ~corrupt_r;
        corrupt_r <= 1'b0;
        result_r  <= temp_r ? raw_temperature_value : raw_pressure_value;
      end
    end
  end

  // ----------------------------------------------------------------
  // response staging into the fifo
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      resp_r   <= '0;
      resp_n_r <= '0;
    end else if (cmd_stb_r) begin
      resp_n_r <= '0;
      if (cmd.kind == pss_pkg::PSS_K_RESULT_READ) begin
        resp_r   <= (valid_r && !busy_r) ? result_r : '0;
        resp_n_r <= `PSS_RESP_RESULT_BYTES;
      end else if (cmd.kind == pss_pkg::PSS_K_CAL_READ) begin
        resp_r   <= {cal_r[cmd.field], 8'h00};
        resp_n_r <= `PSS_RESP_CAL_BYTES;
      end
    end else if (resp_n_r != '0 && fifo_ready) begin
      resp_r   <= {resp_r[15:0], 8'h00};
      resp_n_r <= resp_n_r - 1'b1;
    end
  end

  pss_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .mclk      (mclk),
    .resetn    (resetn),
    .flush     (cmd_stb_r),
    .in_valid  (resp_n_r != '0),
    .in_ready  (fifo_ready),
    .in_data   (resp_r[23:16]),
    .out_valid (fifo_valid),
    .out_ready (load_byte),
    .out_data  (fifo_data)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_SPI_NO_SDA: assert property (@(posedge mclk) disable iff (!resetn)
    spi_mode |-> sda_oe_n) else $error("data line driven in spi mode");
  AST_CONV_BUSY: assert property (@(posedge mclk) disable iff (!resetn)
    (cmd_stb_r && cmd.kind == pss_pkg::PSS_K_CONVERT && !busy_r) |=> busy_r [*3])
    else $error("conversion start did not hold busy");
  AST_NO_VALID_BUSY: assert property (@(posedge mclk) disable iff (!resetn)
    busy_r |-> !valid_r) else $error("result valid while busy");
  AST_READ_CLEARS: assert property (@(posedge mclk) disable iff (!resetn)
    (cmd_stb_r && cmd.kind == pss_pkg::PSS_K_RESULT_READ && !conv_done) |=> !valid_r)
    else $error("repeated read would not return zero");
  AST_READ_ZERO: assert property (@(posedge mclk) disable iff (!resetn)
    (cmd_stb_r && cmd.kind == pss_pkg::PSS_K_RESULT_READ && busy_r) |=> resp_r == '0)
    else $error("read during conversion not zero");
  AST_CAL_WORD: assert property (@(posedge mclk) disable iff (!resetn)
    (cmd_stb_r && cmd.kind == pss_pkg::PSS_K_CAL_READ)
      |=> resp_r[23:8] == $past(cal_r[cmd.field]) && resp_n_r == `PSS_RESP_CAL_BYTES)
    else $error("calibration word mismatch");
  AST_RESET_LOAD: assert property (@(posedge mclk) disable iff (!resetn)
    (cmd_stb_r && cmd.kind == pss_pkg::PSS_K_RESET) |=> cal_r == $past(calibration_memory)
      && !busy_r) else $error("reset command did not reload");
  AST_IGNORE_UNKNOWN: assert property (@(posedge mclk) disable iff (!resetn)
    (cmd_stb_r && cmd.kind == pss_pkg::PSS_K_NONE && !conv_done)
      |=> $stable(busy_r) && $stable(result_r) && $stable(valid_r))
    else $error("unknown command changed state");
  AST_ADDR_BIT: assert property (@(posedge mclk) disable iff (!resetn)
    my_addr[0] == ~flt_r.cs_n && my_addr[6:1] == `PSS_I2C_ADDR_PREFIX)
    else $error("i2c address mismatch");
endmodule : pss_port

// *** verification/pss_host.sv ***
`timescale 1ns/1ns

// ----------------------------------------------------------------
// host model: spi and i2c master, bit-banged off the fast clock
// ----------------------------------------------------------------
module pss_host (
  input  wire logic mclk,
  input  wire logic sdo,
  input  wire logic sda_o,
  input  wire logic sda_oe_n,
  output logic      sclk,
  output logic      sdi_sda,
  output logic      cs_n
);
  logic drv;

  // wired-and with pull-up; in spi the device never enables its driver
  assign sdi_sda = drv & (sda_oe_n | sda_o);

  initial begin
    sclk = 1'b0;
    drv  = 1'b1;
    cs_n = 1'b1;
  end

  // half of the 160 ns link period
  task automatic half;
    repeat (8) @(negedge mclk);
  endtask : half

  // ----------------------------------------------------------------
  // spi frame: one command byte, then n response bits
  // ----------------------------------------------------------------
  // response is sampled late in the high phase, well after the device's sync delay
  task automatic spi(input logic m3, input logic [7:0] cmd, input int n,
                     output logic [23:0] rx);
    sclk = m3;
    half();
    cs_n = 1'b0;
    for (int k = 0; k < 8 + n; k++) begin
      if (k > 0) rx = {rx[22:0], sdo};
      sclk = 1'b0;
      drv  = (k < 8) ? cmd[7 - k] : 1'b0;
      half();
      sclk = 1'b1;
      half();
    end
    rx = {rx[22:0], sdo};
    if (!m3) begin
      sclk = 1'b0;
      half();
    end
    cs_n = 1'b1;
    drv  = ~drv;
    half();
  endtask : spi

  // ----------------------------------------------------------------
  // i2c conditions and nine-clock byte slots
  // ----------------------------------------------------------------
  task automatic i2c_start;
    half();
    drv  = 1'b1;
    half();
    sclk = 1'b1;
    half();
    drv  = 1'b0;
    half();
    sclk = 1'b0;
  endtask : i2c_start

  // bus idle for i2c: clock and data both released high
  task automatic i2c_idle;
    sclk = 1'b1;
    drv  = 1'b1;
  endtask : i2c_idle

  task automatic i2c_stop;
    half();
    drv  = 1'b0;
    half();
    sclk = 1'b1;
    half();
    drv  = 1'b1;
    half();
  endtask : i2c_stop

  // data moves two cycles after the fall so it never looks like a start or stop
  task automatic i2c_byte(input logic [8:0] tx, output logic [8:0] rx);
    for (int k = 8; k >= 0; k--) begin
      repeat (2) @(negedge mclk);
      drv = tx[k];
      half();
      sclk = 1'b1;
      repeat (4) @(negedge mclk);
      rx[k] = sdi_sda;
      repeat (4) @(negedge mclk);
      sclk = 1'b0;
    end
  endtask : i2c_byte
endmodule : pss_host

// *** verification/tb.sv ***
`timescale 1ns/1ns
`include "pss_regs.svh"

`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end

module tb;
  localparam int CONV [5] = '{400, 600, 800, 1000, 1200};
  logic         mclk = 1'b0;
  logic         resetn;
  logic         ps;
  logic         sclk, sdi_sda, cs_n, sdo, sda_o, sda_oe_n, busy;
  logic [127:0] cal;
  logic [23:0]  rawp, rawt, rx;
  logic [8:0]   r9, hi;
  int           n_mismatch = 0;
  int           checked = 0;

  always #5 mclk = ~mclk;

  pss_port #(.CONV_CYC_256(CONV[0]), .CONV_CYC_512(CONV[1]), .CONV_CYC_1024(CONV[2]),
    .CONV_CYC_2048(CONV[3]), .CONV_CYC_4096(CONV[4]), .FIFO_DEPTH(8)) DUT (
    .mclk(mclk), .resetn(resetn), .sclk(sclk), .sdi_sda_in(sdi_sda), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .sdo(sdo), .select_line_low_active_n(cs_n),
    .protocol_select_pin(ps), .calibration_memory(cal), .raw_pressure_value(rawp),
    .raw_temperature_value(rawt), .conversion_busy(busy));

  pss_host HOST (.mclk(mclk), .sdo(sdo), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .sclk(sclk), .sdi_sda(sdi_sda), .cs_n(cs_n));

  function automatic logic [15:0] cw(input int k);
    return 16'(16'h5A00 + k * 16'h0111);
  endfunction : cw

  task automatic wait_idle;
    int t;
    t = 0;
    while (busy !== 1'b0 && t < 3000) begin
      @(negedge mclk);
      t++;
    end
    `CHK(busy, 1'b0)
  endtask : wait_idle

  task automatic stop_test;
    $display("checked %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  initial begin
    repeat (60000) @(posedge mclk);
    n_mismatch++;
    stop_test();
  end

  initial begin
    ps     = 1'b0;
    resetn = 1'b0;
    rawp   = 24'h9C3A51;
    rawt   = 24'hB317E4;
    for (int k = 0; k < 8; k++) cal[16 * k +: 16] = cw(k);
    repeat (6) @(negedge mclk);
    `CHK({sdo, busy, sda_oe_n}, 3'h1)
    resetn = 1'b1;
    repeat (8) @(negedge mclk);
    HOST.spi(1'b0, `PSS_CMD_RESET, 0, rx);
    for (int k = 0; k < 8; k++) begin
      HOST.spi(k[0], 8'hA0 | 8'(2 * k), 16, rx);
      `CHK(rx[15:0], cw(k))
    end
    $display("test calibration done");
    HOST.spi(1'b1, 8'h00, 24, rx);
    `CHK(rx, 24'h0)
    // every ratio of both kinds; the host waits out each conversion
    for (int k = 0; k < 10; k++) begin
      HOST.spi(k[0], 8'h40 + 8'(2 * (k % 5)) + ((k >= 5) ? 8'h10 : 8'h00), 0, rx);
      `CHK(busy, 1'b1)
      wait_idle();
      HOST.spi(~k[0], 8'h00, 24, rx);
      `CHK(rx, (k >= 5) ? rawt : rawp)
      HOST.spi(k[0], 8'h00, 24, rx);
      `CHK(rx, 24'h0)
    end
    $display("test conversions done");
    HOST.spi(1'b0, 8'h48, 0, rx);
    HOST.spi(1'b1, 8'h00, 24, rx);
    `CHK(rx, 24'h0)
    `CHK(busy, 1'b1)
    wait_idle();
    HOST.spi(1'b0, 8'h00, 24, rx);
    `CHK(rx, 24'h0)
    HOST.spi(1'b0, 8'h50, 0, rx);
    wait_idle();
    HOST.spi(1'b1, 8'h33, 0, rx);
    `CHK(busy, 1'b0)
    HOST.spi(1'b1, 8'h00, 24, rx);
    `CHK(rx, rawt)
    $display("test read during conversion and unknown code done");
    // i2c with the select strap high, so the address ends in zero
    ps = 1'b1;
    HOST.i2c_idle();
    repeat (16) @(negedge mclk);
    HOST.i2c_start();
    HOST.i2c_byte({6'h3B, 1'b1, 1'b0, 1'b1}, r9);
    `CHK(r9[0], 1'b1)
    HOST.i2c_stop();
    HOST.i2c_start();
    HOST.i2c_byte({6'h3B, 1'b0, 1'b0, 1'b1}, r9);
    `CHK(r9[0], 1'b0)
    HOST.i2c_byte({8'hA6, 1'b1}, r9);
    `CHK(r9[0], 1'b0)
    HOST.i2c_start();
    HOST.i2c_byte({6'h3B, 1'b0, 1'b1, 1'b1}, r9);
    `CHK(r9[0], 1'b0)
    HOST.i2c_byte({8'hFF, 1'b0}, hi);
    HOST.i2c_byte({8'hFF, 1'b1}, r9);
    HOST.i2c_stop();
    `CHK({hi[8:1], r9[8:1]}, cw(3))
    // recovery: free clocks with the line released, then a reset command
    HOST.i2c_byte(9'h1FF, r9);
    HOST.i2c_start();
    HOST.i2c_byte({6'h3B, 1'b0, 1'b0, 1'b1}, r9);
    `CHK(r9[0], 1'b0)
    HOST.i2c_byte({`PSS_CMD_RESET, 1'b1}, r9);
    `CHK(r9[0], 1'b0)
    HOST.i2c_stop();
    `CHK(busy, 1'b0)
    $display("test i2c done");
    stop_test();
  end
endmodule : tb
